// ==== logic/dwb_consts.svh ====
/*
 Offsets, field positions, reset values and counts of the write-burst capture block.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef DWB_CONSTS_SVH
`define DWB_CONSTS_SVH
`define DWB_CTRL_OFF     4'h0
`define DWB_STATUS_OFF   4'h4
`define DWB_DATA_OFF     4'h8
`define DWB_APCNT_OFF    4'hC
`define DWB_CTRL_BL8     0
`define DWB_CTRL_CL_LO   1
`define DWB_CTRL_CL_HI   3
`define DWB_CTRL_RST     32'h0000_0006
`define DWB_BEATS_BL4    5'h04
`define DWB_BEATS_BL8    5'h08
`define DWB_TRUNC_BEATS  5'h04
`define DWB_TRUNC_GAP    3'h2
`define DWB_CMD_WRITE    4'h4
`define DWB_CMD_READ     4'h5
`define DWB_CMD_PRE      4'h2
`define DWB_TWR_NS       15
`define DWB_TWTR_NS      8
`define DWB_TCK_NS       800
`define DWB_RESP_OKAY    2'h0
`define DWB_RESP_SLVERR  2'h2
`endif

// ==== logic/dwb_pkg.sv ====
/*
 Types of the write-burst capture block.
 Assumes nothing beyond the constants header.
*/
`include "dwb_consts.svh"
package dwb_pkg;
   typedef enum logic [2:0] {
      DWB_IDLE = 3'h1,
      DWB_WAIT = 3'h2,
      DWB_DATA = 3'h4
   } dwb_state_t;
endpackage

// ==== logic/dwb_write_burst.sv ====
/*
 Write-burst capture logic of a DDR2 memory device with an AXI4-Lite register slave.
 Assumes that all memory pins arrive asynchronously and that the controller keeps
 its own timing duties; CK and DQS are sampled by aclk, which runs much faster.
*/
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "dwb_consts.svh"
module dwb_write_burst (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ck,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic        a10,
   input  wire logic [1:0]  ba,
   input  wire logic        dqs_in,
   input  wire logic [7:0]  dq_in,
   input  wire logic        dm_in,
   output      logic [7:0]  dq_out,
   output      logic        dq_oe,
   output      logic        dqs_oe,
   output      logic        wr_valid,
   output      logic [7:0]  wr_data,
   output      logic        wr_mask,
   output      logic        ap_done,
   output      logic [1:0]  ap_bank
);
   // Pin synchronisers; stage one feeds stage two only.
   logic [17:0] pin_s1;
   logic [17:0] pin_s2;
   logic        ck_d;
   logic        dqs_d;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1 <= 18'h00000;
         pin_s2 <= 18'h00000;
         ck_d   <= 1'b0;
         dqs_d  <= 1'b0;
      end else begin
         pin_s1 <= {ck, dqs_in, cs_n, ras_n, cas_n, we_n, a10, ba, dm_in, dq_in};
         pin_s2 <= pin_s1;
         ck_d   <= pin_s2[17];
         dqs_d  <= pin_s2[16];
      end
   end

   wire       ck_rise  = pin_s2[17] & ~ck_d;
   wire       dqs_rise = pin_s2[16] & ~dqs_d;
   wire       dqs_edge = pin_s2[16] ^ dqs_d;
   wire [3:0] cmd      = pin_s2[15:12];
   wire       a10_s    = pin_s2[11];
   wire [1:0] ba_s     = pin_s2[10:9];
   wire       dm_s     = pin_s2[8];
   wire [7:0] dq_s     = pin_s2[7:0];

   // Control register written by software; beat and auto precharge counters.
   logic [31:0] ctrl;
   logic [15:0] beat_cnt;
   logic [15:0] ap_cnt;
   wire         bl8       = ctrl[`DWB_CTRL_BL8];
   wire  [2:0]  read_lat  = ctrl[`DWB_CTRL_CL_HI:`DWB_CTRL_CL_LO];
   wire  [2:0]  write_lat = read_lat - 3'h1;
   wire  [4:0]  bl_beats  = bl8 ? `DWB_BEATS_BL8 : `DWB_BEATS_BL4;

   // Burst tracking; commands are taken on every CK rise, any bank, so an
   // auto precharge in flight never blocks another bank.
   logic [4:0]  beats_left;
   logic [2:0]  since_wr;
   logic        ap_pend;
   logic [1:0]  ap_bank_q;
   dwb_pkg::dwb_state_t state;
   wire  wr_cmd   = ck_rise & (cmd == `DWB_CMD_WRITE);
   wire  trunc    = wr_cmd & bl8 & (since_wr == `DWB_TRUNC_GAP - 3'h1)
                  & (beats_left > `DWB_TRUNC_BEATS);
   wire  started  = (state == dwb_pkg::DWB_DATA);
   wire  cap      = dqs_edge & (beats_left != 5'h00) & (started | dqs_rise);
   wire  [4:0] add_beats  = wr_cmd ? bl_beats : 5'h00;
   wire  [4:0] sub_beats  = trunc ? `DWB_TRUNC_BEATS : 5'h00;
   wire  [4:0] next_beats = beats_left - {4'h0, cap} + add_beats - sub_beats;
   wire  burst_end  = (beats_left != 5'h00) & (next_beats == 5'h00);
   wire  next_ap    = wr_cmd ? (a10_s | ap_pend) : (ap_pend & ~burst_end);
   wire  dwb_pkg::dwb_state_t next_state =
         (next_beats == 5'h00)  ? dwb_pkg::DWB_IDLE :
         (started | cap)        ? dwb_pkg::DWB_DATA : dwb_pkg::DWB_WAIT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         beats_left <= 5'h00;
         since_wr   <= 3'h7;
         ap_pend    <= 1'b0;
         ap_bank_q  <= 2'h0;
         state      <= dwb_pkg::DWB_IDLE;
      end else begin
         beats_left <= next_beats;
         state      <= next_state;
         ap_pend    <= next_ap;
         if (wr_cmd) begin
            since_wr <= 3'h0;
         end else if (ck_rise && since_wr != 3'h7) begin
            since_wr <= since_wr + 3'h1;
         end
         if (wr_cmd && a10_s) begin
            ap_bank_q <= ba_s;
         end
      end
   end

   // Data capture and auto precharge outputs; the data pins are never driven.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_valid <= 1'b0;
         wr_data  <= 8'h00;
         wr_mask  <= 1'b0;
         ap_done  <= 1'b0;
         ap_bank  <= 2'h0;
         dq_out   <= 8'h00;
         dq_oe    <= 1'b0;
         dqs_oe   <= 1'b0;
         beat_cnt <= 16'h0000;
         ap_cnt   <= 16'h0000;
      end else begin
         wr_valid <= cap;
         if (cap) begin
            wr_data  <= dq_s;
            wr_mask  <= dm_s;
            beat_cnt <= beat_cnt + 16'h0001;
         end
         ap_done <= burst_end & ap_pend;
         if (burst_end && ap_pend) begin
            ap_bank <= ap_bank_q;
            ap_cnt  <= ap_cnt + 16'h0001;
         end
      end
   end

   // AXI4-Lite slave: address and data may arrive in either order.
   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   wire         do_write = aw_held & w_held & ~s_axi_bvalid;
   wire         wr_ok    = (aw_addr == `DWB_CTRL_OFF);
   wire  [31:0] rd_mux   =
         (s_axi_araddr == `DWB_CTRL_OFF)   ? ctrl :
         (s_axi_araddr == `DWB_STATUS_OFF) ? {8'h00, state, 5'h00, write_lat, beats_left, 8'h00} :
         (s_axi_araddr == `DWB_DATA_OFF)   ? {beat_cnt, 7'h00, wr_mask, wr_data} :
         (s_axi_araddr == `DWB_APCNT_OFF)  ? {14'h0000, ap_bank, ap_cnt} : 32'h0000_0000;
   wire         rd_ok    = (s_axi_araddr[1:0] == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DWB_RESP_OKAY;
         ctrl          <= `DWB_CTRL_RST;
      end else begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `DWB_RESP_OKAY : `DWB_RESP_SLVERR;
            if (wr_ok && w_strb[0]) begin
               ctrl[7:0] <= w_data[7:0];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `DWB_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? `DWB_RESP_OKAY : `DWB_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   default clocking dwb_cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence dwb_last_beat;
      ap_pend && beats_left == 5'h01 && cap && !wr_cmd;
   endsequence

   chk_dq_not_driven: assert property (!dq_oe && !dqs_oe)
      else $error("Data pins driven during write path.");
   chk_capture_in_burst: assert property (wr_valid |-> $past(beats_left) != 5'h00)
      else $error("Data captured outside a burst.");
   chk_first_on_rise: assert property ($rose(wr_valid) && $past(state) != dwb_pkg::DWB_DATA
      |-> $past(dqs_rise))
      else $error("First beat not taken on a rising strobe.");
   chk_idle_ignores: assert property (beats_left == 5'h00 && !wr_cmd |=> !wr_valid)
      else $error("Extra data accepted while idle.");
   chk_write_extends: assert property (wr_cmd && !trunc
      |=> beats_left == $past(beats_left) - {4'h0, $past(cap)} + $past(bl_beats))
      else $error("Write did not extend the burst by its length.");
   chk_ap_armed: assert property (wr_cmd && a10_s |=> ap_pend && ap_bank_q == $past(ba_s))
      else $error("Address bit ten did not arm auto precharge.");
   chk_ap_fires: assert property (dwb_last_beat |=> ap_done ##1 !ap_done)
      else $error("Auto precharge did not fire once at burst end.");
   chk_wl_derived: assert property (s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready)
      && $past(s_axi_araddr) == `DWB_STATUS_OFF
      |-> s_axi_rdata[15:13] == $past(read_lat) - 3'h1)
      else $error("Write latency not read latency minus one.");
endmodule

// ==== tb/dwb_ctl_model.sv ====
/*
 Memory controller model that issues commands and strobes write data.
 Assumes write latency 2 and a free running command clock.
*/
`timescale 1ns/10ps
`include "dwb_consts.svh"
module dwb_ctl_model (
   output logic       ck,
   output logic       cs_n,
   output logic       ras_n,
   output logic       cas_n,
   output logic       we_n,
   output logic       a10,
   output logic [1:0] ba,
   output logic       dqs,
   output logic [7:0] dq,
   output logic       dm
);
   // Far-side spacings in CK cycles, rounded up from nanoseconds; write-to-read is held to at least 2.
   localparam int WR_CK   = (`DWB_TWR_NS + `DWB_TCK_NS - 1) / `DWB_TCK_NS;
   localparam int WTR_RAW = (`DWB_TWTR_NS + `DWB_TCK_NS - 1) / `DWB_TCK_NS;
   localparam int WTR_CK  = (WTR_RAW > 2) ? WTR_RAW : 2;
   int ck_count;
   int wr_end [4];
   always @(posedge ck) ck_count <= ck_count + 1;
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      {a10, ba, dqs, dq, dm} = 13'h0000;
      ck = 1'b0;
      forever #400 ck = ~ck;
   end
   // Issues one write command, then no-ops.
   task automatic cmd(input logic ap, input logic [1:0] b);
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n, a10, ba} = {`DWB_CMD_WRITE, ap, b};
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
   endtask
   // Strobes n beats, first rise two clocks after the command.
   task automatic burst(input int n, input logic [7:0] d0);
      @(posedge ck);
      @(negedge ck);
      for (int i = 0; i < n; i++) begin
         #200 dq = d0 + i[7:0];
         dm = &dq[1:0];
         #200 dqs = ~dqs;
      end
      #100 dq = ~dq;
      dm = 1'b0;
   endtask
   // Writes one burst and notes the first CK rise after its last data pair.
   task automatic xfer(input logic ap, input logic [1:0] b, input int n, input logic [7:0] d0);
      cmd(ap, b);
      burst(n, d0);
      @(posedge ck);
      wr_end[b] = ck_count;
   endtask
   // Issues a read or a precharge once the bank's spacing from its write end is met.
   task automatic late(input logic rd, input logic [1:0] b);
      while (ck_count < wr_end[b] + (rd ? WTR_CK : WR_CK)) @(posedge ck);
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n, a10, ba} = {rd ? `DWB_CMD_READ : `DWB_CMD_PRE, 1'b0, b};
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
   endtask
   // Toggles the strobe with no command pending.
   task automatic stray();
      dq = 8'hEE;
      repeat (4) #400 dqs = ~dqs;
   endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 Self-checking bench of the write-burst capture block.
 Assumes the controller model and the constants header.
*/
`timescale 1ns/10ps
`include "dwb_consts.svh"
module tb_top;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, ck, cs_n, ras_n, cas_n, we_n, a10, dqs_in, dm_in;
   logic        dq_oe, dqs_oe, wr_valid, wr_mask, ap_done;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, ba, ap_bank;
   logic [7:0]  dq_in, dq_out, wr_data;
   int          fail_count, num_checks, ap_seen;
   logic [8:0]  got[$];
   dwb_write_burst dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ck, .cs_n, .ras_n, .cas_n, .we_n, .a10, .ba, .dqs_in,
      .dq_in, .dm_in, .dq_out, .dq_oe, .dqs_oe, .wr_valid, .wr_data, .wr_mask, .ap_done,
      .ap_bank);
   dwb_ctl_model ctl_u (.ck, .cs_n, .ras_n, .cas_n, .we_n, .a10, .ba, .dqs(dqs_in),
      .dq(dq_in), .dm(dm_in));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (wr_valid === 1'b1) got.push_back({wr_mask, wr_data});
      if (ap_done === 1'b1) ap_seen++;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic beats(input int n, input logic [7:0] d0);
      logic [7:0] v;
      repeat (40) @(posedge aclk);
      chk("beat count", got.size(), n);
      foreach (got[i]) begin
         v = d0 + i[7:0];
         chk("beat", {23'h0, got[i]}, {23'h0, &v[1:0], v});
      end
      chk("pins driven", {30'h0, dq_oe, dqs_oe}, 32'h0);
      got.delete();
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw | (s_axi_awready === 1'b1);
         w = w | (s_axi_wready === 1'b1);
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      axr(`DWB_CTRL_OFF, d);
      chk("ctrl reset", d, `DWB_CTRL_RST);
      axr(`DWB_STATUS_OFF, d);
      chk("write latency", {29'h0, d[15:13]}, 32'h2);
      axw(`DWB_DATA_OFF, 32'h0, r);
      chk("refused write", {30'h0, r}, {30'h0, `DWB_RESP_SLVERR});
      axw(`DWB_CTRL_OFF, 32'h9, r);
      axr(`DWB_STATUS_OFF, d);
      chk("latency four", {29'h0, d[15:13]}, 32'h3);
      axw(`DWB_CTRL_OFF, `DWB_CTRL_RST, r);
      $display("test regs done");
   endtask
   task automatic t_bursts();
      ctl_u.xfer(1'b0, 2'h1, 4, 8'h10);
      beats(4, 8'h10);
      chk("no precharge", ap_seen, 0);
      ctl_u.late(1'b1, 2'h1);
      ctl_u.late(1'b0, 2'h2);
      ctl_u.stray();
      beats(0, 8'h00);
      @(posedge ck);
      fork
         ctl_u.xfer(1'b1, 2'h0, 4, 8'h20);
         #1600 ctl_u.xfer(1'b0, 2'h2, 4, 8'h24);
      join
      beats(8, 8'h20);
      chk("stream precharge", ap_seen, 1);
      chk("stream bank", {30'h0, ap_bank}, 32'h0);
      ctl_u.xfer(1'b1, 2'h3, 4, 8'h40);
      ctl_u.late(1'b0, 2'h1);
      beats(4, 8'h40);
      chk("precharge count", ap_seen, 2);
      chk("precharge bank", {30'h0, ap_bank}, 32'h3);
      $display("test bursts done");
   endtask
   task automatic t_trunc();
      logic [1:0]  r;
      logic [31:0] d;
      axw(`DWB_CTRL_OFF, 32'h7, r);
      @(posedge ck);
      fork
         ctl_u.xfer(1'b0, 2'h0, 4, 8'h60);
         #1600 ctl_u.xfer(1'b0, 2'h1, 8, 8'h64);
      join
      beats(12, 8'h60);
      axr(`DWB_STATUS_OFF, d);
      chk("truncated left", {27'h0, d[12:8]}, 32'h0);
      chk("truncated idle", {29'h0, d[23:21]}, 32'h1);
      ctl_u.wr_end[0] = ctl_u.wr_end[0] + 2;
      ctl_u.late(1'b0, 2'h0);
      beats(0, 8'h00);
      $display("test truncate done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #2000000;
      fail_count++;
      wrap_up();
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      s_axi_wstrb = 4'hF;
      {fail_count, num_checks, ap_seen} = 96'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_regs();
      t_bursts();
      t_trunc();
      wrap_up();
   end
endmodule
